// ==== cpu_core_model.sv ====
`timescale 1ns/1ps
module cpu_core_model (
    input  wire logic        mclk,
    input  wire logic        nrst,
    input  wire logic        int_req,
    input  wire logic [15:0] int_vector,
    input  wire logic [1:0]  ack_delay,
    output logic             int_ack,
    output logic      [15:0] taken_vector,
    output logic      [7:0]  taken_count
);
    logic [1:0] waited;
    // Ack only while a request stands; a slow core lets the vector settle first
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            int_ack      <= 1'b0;
            waited       <= 2'h0;
            taken_vector <= 16'h0000;
            taken_count  <= 8'h00;
        end else begin
            int_ack <= 1'b0;
            waited  <= 2'h0;
            if (int_ack && int_req) begin
                taken_vector <= int_vector;
                taken_count  <= taken_count + 8'h01;
            end else if (int_req && !int_ack) begin
                waited  <= waited + 2'h1;
                int_ack <= (waited == ack_delay);
            end
        end
    end
endmodule

// ==== irq_checker_properties.sv ====
`timescale 1ns/1ps
module irq_checker (
    input wire logic        mclk,
    input wire logic        nrst,
    input wire logic [7:0]  reg_addr,
    input wire logic        reg_rd,
    input wire logic [7:0]  reg_rdata,
    input wire logic        int_ack,
    input wire logic        int_req,
    input wire logic [15:0] int_vector,
    input wire logic [3:0]  int_source,
    input wire logic        irq
);
    // Offsets the decoder answers on; anything else must read as zero
    logic mapped;
    assign mapped = reg_addr inside {8'hA8, 8'hB1, 8'hB2, 8'hB3, 8'hB7, 8'hB8, 8'hD9, 8'hDA, 8'hDB};
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);
    a_rdata_one_slot: assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("read data outside its slot");
    a_unmapped_reads_zero: assert property (reg_rd && !mapped |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_vector_by_source: assert property (int_req |->
        int_vector == irq_ctrl_pkg::VECTOR_BY_POLL[int_source])
        else $error("vector does not match source");
    a_source_in_range: assert property (int_req |-> int_source < 4'h9)
        else $error("source index out of range");
    a_no_empty_vector: assert property (int_req |-> int_vector != 16'h0043)
        else $error("vector without source presented");
    a_ack_drops_req: assert property (int_req && int_ack |=> !int_req)
        else $error("request stands after ack");
    a_vector_holds_idle: assert property (!int_req ##1 !int_req |-> $stable(int_vector))
        else $error("vector moved while idle");
    a_quiet_after_reset: assert property ($rose(nrst) |-> !int_req && !irq
        && int_vector == 16'h0000)
        else $error("outputs not at reset values");
endmodule
bind irq_controller irq_checker irq_checker_inst (.mclk, .nrst, .reg_addr, .reg_rd, .reg_rdata,
    .int_ack, .int_req, .int_vector, .int_source, .irq);

// ==== irq_controller.sv ====
// Decided for this implementation: strobed register access.
`timescale 1ns/1ps
module irq_controller (
    input  wire logic        mclk,
    input  wire logic        nrst,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    input  wire logic        bit_wr,
    input  wire logic [2:0]  bit_sel,
    input  wire logic        bit_val,
    input  wire logic        ext0_request_flag,
    input  wire logic        timer0_overflow_flag,
    input  wire logic        ext1_request_flag,
    input  wire logic        timer1_overflow_flag,
    input  wire logic        uart_rx_flag,
    input  wire logic        uart_tx_flag,
    input  wire logic        timer2_overflow_flag,
    input  wire logic        timer2_external_flag,
    input  wire logic        counter_overflow_flag,
    input  wire logic [4:0]  compare_module_flags,
    input  wire logic        keypad_request,
    input  wire logic        spi_request,
    input  wire logic        int_ack,
    input  wire logic        int_return,
    output logic             int_req,
    output logic      [15:0] int_vector,
    output logic      [1:0]  int_level,
    output logic      [3:0]  int_source,
    output logic             irq
);

    localparam int NS = irq_ctrl_pkg::NUM_SRC;
    localparam int EW = irq_ctrl_pkg::EVT_W;

    // Software-visible registers
    logic [7:0]    irq_enable_main;
    logic [7:0]    irq_enable_aux;
    logic [7:0]    irq_priority_low_main;
    logic [7:0]    irq_priority_high_main;
    logic [7:0]    prio_low_aux;
    logic [7:0]    prio_high_aux;
    logic [EW-1:0] evt_status;
    logic [EW-1:0] evt_mask;

    // One bit per level currently in service
    logic [3:0]    in_service;

    logic [NS-1:0] src_req;
    logic [NS-1:0] src_on;
    logic          global_irq_gate;
    logic          ack_now;
    logic          act_any;
    logic [1:0]    act_lvl;
    logic          next_req;
    logic [3:0]    next_in_service;
    logic [EW-1:0] evt_set;
    logic [EW-1:0] evt_clr;
    logic [7:0]    next_rdata;

    irq_pick_if #(.N(NS), .IW(4)) pick_bus ();

    irq_pick #(
        .N  (NS),
        .IW (4)
    ) u_pick (
        .pick (pick_bus.picker)
    );

    // Byte write or single-bit write, limited to the writable bits
    function automatic logic [7:0] reg_update(
        input logic [7:0] cur,
        input logic [7:0] wmask,
        input logic       hit_byte,
        input logic       hit_bit,
        input logic [2:0] sel,
        input logic       val,
        input logic [7:0] wdata
    );
        logic [7:0] v;
        v = cur;
        if (hit_byte) begin
            v = wdata & wmask;
        end else if (hit_bit) begin
            v[sel] = val;
            v      = v & wmask;
        end
        return v;
    endfunction

    // Highest level in service and whether any is active
    function automatic logic [2:0] top_level(input logic [3:0] svc);
        logic [2:0] r;
        r = 3'b000;
        for (int i = 0; i < 4; i++) begin
            if (svc[i]) begin
                r = {1'b1, 2'(i)};
            end
        end
        return r;
    endfunction

    function automatic logic byte_hit(input logic [7:0] a, input logic [7:0] ofs, input logic s);
        return s && (a == ofs);
    endfunction

    // Request lines, one per polling position
    always_comb begin
        src_req = '0;
        src_req[irq_ctrl_pkg::POLL_EXT0]        = ext0_request_flag;
        src_req[irq_ctrl_pkg::POLL_TIMER0]      = timer0_overflow_flag;
        src_req[irq_ctrl_pkg::POLL_EXT1]        = ext1_request_flag;
        src_req[irq_ctrl_pkg::POLL_TIMER1]      = timer1_overflow_flag;
        src_req[irq_ctrl_pkg::POLL_COUNTER_ARR] = counter_overflow_flag
                                                | (|compare_module_flags);
        src_req[irq_ctrl_pkg::POLL_UART]        = uart_rx_flag | uart_tx_flag;
        src_req[irq_ctrl_pkg::POLL_TIMER2]      = timer2_overflow_flag
                                                | timer2_external_flag;
        src_req[irq_ctrl_pkg::POLL_KEYPAD]      = keypad_request;
        src_req[irq_ctrl_pkg::POLL_SPI]         = spi_request;
    end

    // Individual enables mapped onto polling positions
    always_comb begin
        src_on = '0;
        src_on[irq_ctrl_pkg::POLL_EXT0]        = irq_enable_main[irq_ctrl_pkg::BIT_EXT0];
        src_on[irq_ctrl_pkg::POLL_TIMER0]      = irq_enable_main[irq_ctrl_pkg::BIT_TIMER0];
        src_on[irq_ctrl_pkg::POLL_EXT1]        = irq_enable_main[irq_ctrl_pkg::BIT_EXT1];
        src_on[irq_ctrl_pkg::POLL_TIMER1]      = irq_enable_main[irq_ctrl_pkg::BIT_TIMER1];
        src_on[irq_ctrl_pkg::POLL_COUNTER_ARR] = irq_enable_main[irq_ctrl_pkg::BIT_COUNTER_ARR];
        src_on[irq_ctrl_pkg::POLL_UART]        = irq_enable_main[irq_ctrl_pkg::BIT_SERIAL];
        src_on[irq_ctrl_pkg::POLL_TIMER2]      = irq_enable_main[irq_ctrl_pkg::BIT_TIMER2];
        src_on[irq_ctrl_pkg::POLL_KEYPAD]      = irq_enable_aux[irq_ctrl_pkg::BIT_KEYPAD];
        src_on[irq_ctrl_pkg::POLL_SPI]         = irq_enable_aux[irq_ctrl_pkg::BIT_SPI];
    end

    // Level per source from its high and low bit pair
    always_comb begin
        pick_bus.lvl = '0;
        pick_bus.lvl[irq_ctrl_pkg::POLL_EXT0] = {
            irq_priority_high_main[irq_ctrl_pkg::BIT_EXT0],
            irq_priority_low_main[irq_ctrl_pkg::BIT_EXT0]};
        pick_bus.lvl[irq_ctrl_pkg::POLL_TIMER0] = {
            irq_priority_high_main[irq_ctrl_pkg::BIT_TIMER0],
            irq_priority_low_main[irq_ctrl_pkg::BIT_TIMER0]};
        pick_bus.lvl[irq_ctrl_pkg::POLL_EXT1] = {
            irq_priority_high_main[irq_ctrl_pkg::BIT_EXT1],
            irq_priority_low_main[irq_ctrl_pkg::BIT_EXT1]};
        pick_bus.lvl[irq_ctrl_pkg::POLL_TIMER1] = {
            irq_priority_high_main[irq_ctrl_pkg::BIT_TIMER1],
            irq_priority_low_main[irq_ctrl_pkg::BIT_TIMER1]};
        pick_bus.lvl[irq_ctrl_pkg::POLL_COUNTER_ARR] = {
            irq_priority_high_main[irq_ctrl_pkg::BIT_COUNTER_ARR],
            irq_priority_low_main[irq_ctrl_pkg::BIT_COUNTER_ARR]};
        pick_bus.lvl[irq_ctrl_pkg::POLL_UART] = {
            irq_priority_high_main[irq_ctrl_pkg::BIT_SERIAL],
            irq_priority_low_main[irq_ctrl_pkg::BIT_SERIAL]};
        pick_bus.lvl[irq_ctrl_pkg::POLL_TIMER2] = {
            irq_priority_high_main[irq_ctrl_pkg::BIT_TIMER2],
            irq_priority_low_main[irq_ctrl_pkg::BIT_TIMER2]};
        pick_bus.lvl[irq_ctrl_pkg::POLL_KEYPAD] = {
            prio_high_aux[irq_ctrl_pkg::BIT_KEYPAD],
            prio_low_aux[irq_ctrl_pkg::BIT_KEYPAD]};
        pick_bus.lvl[irq_ctrl_pkg::POLL_SPI] = {
            prio_high_aux[irq_ctrl_pkg::BIT_SPI],
            prio_low_aux[irq_ctrl_pkg::BIT_SPI]};
    end

    // Masked requests go to the picker; flags are never cleared here
    assign global_irq_gate = irq_enable_main[irq_ctrl_pkg::BIT_GLOBAL_GATE];
    assign pick_bus.pend   = src_req & src_on & {NS{global_irq_gate}};

    // Nesting state and the decision to raise a request
    assign ack_now            = int_ack && int_req;
    assign {act_any, act_lvl} = top_level(in_service);

    // Acked request drops for a cycle so the core can clear its flag first
    always_comb begin
        next_req = pick_bus.valid && !ack_now
                && (!act_any || pick_bus.level > act_lvl);
    end

    // Return releases the top level, acceptance records the new one
    always_comb begin
        next_in_service = in_service;
        if (int_return && act_any) begin
            next_in_service[act_lvl] = 1'b0;
        end
        if (ack_now) begin
            next_in_service[int_level] = 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            in_service <= 4'h0;
        end else begin
            in_service <= next_in_service;
        end
    end

    // Request, vector, level and source id toward the core
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            int_req    <= 1'b0;
            int_vector <= irq_ctrl_pkg::VECTOR_RESET;
            int_level  <= 2'b00;
            int_source <= 4'h0;
        end else begin
            int_req <= next_req;
            if (next_req) begin
                int_vector <= irq_ctrl_pkg::VECTOR_BY_POLL[pick_bus.idx];
                int_level  <= pick_bus.level;
                int_source <= pick_bus.idx;
            end
        end
    end

    // Enable registers, both bit addressable
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            irq_enable_main <= irq_ctrl_pkg::RST_EN_MAIN;
            irq_enable_aux  <= irq_ctrl_pkg::RST_EN_AUX;
        end else begin
            irq_enable_main <= reg_update(irq_enable_main, irq_ctrl_pkg::MASK_EN_MAIN,
                byte_hit(reg_addr, irq_ctrl_pkg::OFS_EN_MAIN, reg_wr),
                byte_hit(reg_addr, irq_ctrl_pkg::OFS_EN_MAIN, bit_wr),
                bit_sel, bit_val, reg_wdata);
            irq_enable_aux  <= reg_update(irq_enable_aux, irq_ctrl_pkg::MASK_AUX,
                byte_hit(reg_addr, irq_ctrl_pkg::OFS_EN_AUX, reg_wr),
                byte_hit(reg_addr, irq_ctrl_pkg::OFS_EN_AUX, bit_wr),
                bit_sel, bit_val, reg_wdata);
        end
    end

    // Priority registers; high halves ignore single-bit writes
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            irq_priority_low_main  <= irq_ctrl_pkg::RST_PRIO;
            irq_priority_high_main <= irq_ctrl_pkg::RST_PRIO;
            prio_low_aux           <= irq_ctrl_pkg::RST_PRIO;
            prio_high_aux          <= irq_ctrl_pkg::RST_PRIO;
        end else begin
            irq_priority_low_main  <= reg_update(irq_priority_low_main,
                irq_ctrl_pkg::MASK_PRIO_MAIN,
                byte_hit(reg_addr, irq_ctrl_pkg::OFS_PRIO_LO_MAIN, reg_wr),
                byte_hit(reg_addr, irq_ctrl_pkg::OFS_PRIO_LO_MAIN, bit_wr),
                bit_sel, bit_val, reg_wdata);
            irq_priority_high_main <= reg_update(irq_priority_high_main,
                irq_ctrl_pkg::MASK_PRIO_MAIN,
                byte_hit(reg_addr, irq_ctrl_pkg::OFS_PRIO_HI_MAIN, reg_wr),
                1'b0, bit_sel, bit_val, reg_wdata);
            prio_low_aux           <= reg_update(prio_low_aux, irq_ctrl_pkg::MASK_AUX,
                byte_hit(reg_addr, irq_ctrl_pkg::OFS_PRIO_LO_AUX, reg_wr),
                byte_hit(reg_addr, irq_ctrl_pkg::OFS_PRIO_LO_AUX, bit_wr),
                bit_sel, bit_val, reg_wdata);
            prio_high_aux          <= reg_update(prio_high_aux, irq_ctrl_pkg::MASK_AUX,
                byte_hit(reg_addr, irq_ctrl_pkg::OFS_PRIO_HI_AUX, reg_wr),
                1'b0, bit_sel, bit_val, reg_wdata);
        end
    end

    // Controller events for the supervisory interrupt
    always_comb begin
        evt_set = '0;
        evt_set[irq_ctrl_pkg::EVT_ACCEPT]       = ack_now;
        evt_set[irq_ctrl_pkg::EVT_PREEMPT]      = ack_now && act_any;
        evt_set[irq_ctrl_pkg::EVT_RETURN]       = int_return && act_any;
        evt_set[irq_ctrl_pkg::EVT_STRAY_RETURN] = int_return && !act_any;
        evt_clr = byte_hit(reg_addr, irq_ctrl_pkg::OFS_EVT_STATUS, reg_wr)
                ? reg_wdata[EW-1:0] : '0;
    end

    // Set beats write-one-to-clear so no event is lost
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            evt_status <= irq_ctrl_pkg::RST_EVT;
        end else begin
            evt_status <= (evt_status & ~evt_clr) | evt_set;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            evt_mask <= irq_ctrl_pkg::RST_EVT;
        end else if (byte_hit(reg_addr, irq_ctrl_pkg::OFS_EVT_MASK, reg_wr)) begin
            evt_mask <= reg_wdata[EW-1:0];
        end
    end

    // Level output lags the status bit by one cycle to stay registered
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(evt_status & evt_mask);
        end
    end

    // Read mux; reserved bits and unmapped offsets return zero
    always_comb begin
        next_rdata = 8'h00;
        if (reg_rd) begin
            unique case (reg_addr)
                irq_ctrl_pkg::OFS_EN_MAIN:      next_rdata = irq_enable_main;
                irq_ctrl_pkg::OFS_EN_AUX:       next_rdata = irq_enable_aux;
                irq_ctrl_pkg::OFS_PRIO_LO_MAIN: next_rdata = irq_priority_low_main;
                irq_ctrl_pkg::OFS_PRIO_HI_MAIN: next_rdata = irq_priority_high_main;
                irq_ctrl_pkg::OFS_PRIO_LO_AUX:  next_rdata = prio_low_aux;
                irq_ctrl_pkg::OFS_PRIO_HI_AUX:  next_rdata = prio_high_aux;
                irq_ctrl_pkg::OFS_EVT_STATUS:   next_rdata = {4'h0, evt_status};
                irq_ctrl_pkg::OFS_EVT_MASK:     next_rdata = {4'h0, evt_mask};
                irq_ctrl_pkg::OFS_IN_SERVICE:   next_rdata = {4'h0, in_service};
                default:                        next_rdata = 8'h00;
            endcase
        end
    end

    // Data stands only in the cycle after the read strobe
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= next_rdata;
        end
    end

endmodule

// ==== irq_ctrl_pkg.sv ====
package irq_ctrl_pkg;

    // Register offsets in the special register space
    localparam logic [7:0] OFS_EN_MAIN      = 8'hA8;
    localparam logic [7:0] OFS_EN_AUX       = 8'hB1;
    localparam logic [7:0] OFS_PRIO_LO_AUX  = 8'hB2;
    localparam logic [7:0] OFS_PRIO_HI_AUX  = 8'hB3;
    localparam logic [7:0] OFS_PRIO_HI_MAIN = 8'hB7;
    localparam logic [7:0] OFS_PRIO_LO_MAIN = 8'hB8;
    localparam logic [7:0] OFS_EVT_STATUS   = 8'hD9;
    localparam logic [7:0] OFS_EVT_MASK     = 8'hDA;
    localparam logic [7:0] OFS_IN_SERVICE   = 8'hDB;

    // Bit positions of the main enable and main priority registers
    localparam int BIT_EXT0        = 0;
    localparam int BIT_TIMER0      = 1;
    localparam int BIT_EXT1        = 2;
    localparam int BIT_TIMER1      = 3;
    localparam int BIT_SERIAL      = 4;
    localparam int BIT_TIMER2      = 5;
    localparam int BIT_COUNTER_ARR = 6;
    localparam int BIT_GLOBAL_GATE = 7;

    // Bit positions of the auxiliary enable and priority registers
    localparam int BIT_KEYPAD = 0;
    localparam int BIT_SPI    = 2;

    // Writable bits per register; the rest read as zero
    localparam logic [7:0] MASK_EN_MAIN   = 8'hFF;
    localparam logic [7:0] MASK_PRIO_MAIN = 8'h7F;
    localparam logic [7:0] MASK_AUX       = 8'h05;

    // Reset values
    localparam logic [7:0] RST_EN_MAIN = 8'h00;
    localparam logic [7:0] RST_EN_AUX  = 8'h00;
    localparam logic [7:0] RST_PRIO    = 8'h00;
    localparam logic [3:0] RST_EVT     = 4'h0;

    // Sources in polling order, index 0 polled first
    localparam int NUM_SRC          = 9;
    localparam int POLL_EXT0        = 0;
    localparam int POLL_TIMER0      = 1;
    localparam int POLL_EXT1        = 2;
    localparam int POLL_TIMER1      = 3;
    localparam int POLL_COUNTER_ARR = 4;
    localparam int POLL_UART        = 5;
    localparam int POLL_TIMER2      = 6;
    localparam int POLL_KEYPAD      = 7;
    localparam int POLL_SPI         = 8;

    // Vector addresses, indexed by polling position
    localparam logic [15:0] VECTOR_RESET  = 16'h0000;
    localparam logic [15:0] VECTOR_UNUSED = 16'h0043;
    localparam logic [NUM_SRC-1:0][15:0] VECTOR_BY_POLL = {
        16'h004B, 16'h003B, 16'h002B, 16'h0023, 16'h0033,
        16'h001B, 16'h0013, 16'h000B, 16'h0003
    };

    // Event status bits
    localparam int EVT_W            = 4;
    localparam int EVT_ACCEPT       = 0;
    localparam int EVT_PREEMPT      = 1;
    localparam int EVT_RETURN       = 2;
    localparam int EVT_STRAY_RETURN = 3;

endpackage

// ==== irq_pick.sv ====
`timescale 1ns/1ps
module irq_pick #(
    parameter int N  = 9,
    parameter int IW = 4
) (
    irq_pick_if.picker pick
);

    // Index must be able to name every source
    if (N < 1 || N > (1 << IW)) begin : g_bad_size
        $error("irq_pick: source count does not fit the index width");
    end

    // Scan in polling order; only a strictly higher level displaces the
    // current choice, so ties go to the earlier polled source
    always_comb begin
        pick.valid = 1'b0;
        pick.idx   = '0;
        pick.level = 2'b00;
        for (int i = 0; i < N; i++) begin
            if (pick.pend[i] && (!pick.valid || pick.lvl[i] > pick.level)) begin
                pick.valid = 1'b1;
                pick.idx   = IW'(i);
                pick.level = pick.lvl[i];
            end
        end
    end

endmodule

// ==== irq_pick_if.sv ====
`timescale 1ns/1ps
interface irq_pick_if #(
    parameter int N  = 9,
    parameter int IW = 4
);
    logic [N-1:0]      pend;
    logic [N-1:0][1:0] lvl;
    logic              valid;
    logic [IW-1:0]     idx;
    logic [1:0]        level;

    modport picker (
        input  pend,
        input  lvl,
        output valid,
        output idx,
        output level
    );

    modport user (
        output pend,
        output lvl,
        input  valid,
        input  idx,
        input  level
    );
endinterface

// ==== tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
    logic        mclk = 1'b0, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, bit_wr = 1'b0;
    logic        bit_val = 1'b0, int_return = 1'b0, int_ack, int_req, irq;
    logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, alt = 8'h02, taken_count;
    logic [2:0]  bit_sel = 3'h0;
    logic [8:0]  src = 9'h000;
    logic [1:0]  ack_delay = 2'h0, int_level;
    logic [15:0] int_vector, taken_vector;
    logic [3:0]  int_source;
    logic [31:0] lfsr = 32'h3402;
    logic [17:0] lv_now = 18'h0;
    int          num_errors = 0, checked = 0, cycles = 0;
    localparam logic [15:0] VEC [9] = '{16'h0003, 16'h000B, 16'h0013, 16'h001B, 16'h0033,
        16'h0023, 16'h002B, 16'h003B, 16'h004B};
    localparam int BPOS [9] = '{0, 1, 2, 3, 6, 4, 5, 0, 2};
    localparam logic [7:0] ADR [6] = '{8'hA8, 8'hB1, 8'hB2, 8'hB3, 8'hB7, 8'hB8};
    localparam logic [7:0] MSK [6] = '{8'hFF, 8'h05, 8'h05, 8'h05, 8'h7F, 8'h7F};

    irq_controller irq_controller_inst (.mclk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .bit_wr, .bit_sel, .bit_val, .ext0_request_flag(src[0]),
        .timer0_overflow_flag(src[1]), .ext1_request_flag(src[2]),
        .timer1_overflow_flag(src[3]), .counter_overflow_flag(src[4] & alt[0]),
        .compare_module_flags({5{src[4] & !alt[0]}} & alt[5:1]),
        .uart_rx_flag(src[5] & alt[6]), .uart_tx_flag(src[5] & !alt[6]),
        .timer2_overflow_flag(src[6] & alt[7]), .timer2_external_flag(src[6] & !alt[7]),
        .keypad_request(src[7]), .spi_request(src[8]), .int_ack, .int_return, .int_req,
        .int_vector, .int_level, .int_source, .irq);
    cpu_core_model cpu_core_model_inst (.mclk, .nrst, .int_req, .int_vector, .ack_delay,
        .int_ack, .taken_vector, .taken_count);

    // Clock and hang guard
    always #2.5 mclk = ~mclk;
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            give_verdict();
        end
    end

    function automatic logic [31:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction
    // Expected winner: highest level, ties to lowest index; must beat level in service
    function automatic int pick(input logic [8:0] s, input logic [17:0] lv, input int top);
        int b = -1;
        for (int i = 0; i < 9; i++)
            if (s[i] && (b < 0 || lv[2*i+:2] > lv[2*b+:2]))
                b = i;
        if (b >= 0 && int'(lv[2*b+:2]) <= top)
            b = -1;
        return b;
    endfunction
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Mode 0 read, 1 byte write, 2 bit write; read data taken in the slot after the strobe
    task automatic bus(input logic [7:0] a, d, input int m, output logic [7:0] q);
        reg_addr <= a;
        reg_wdata <= d;
        bit_sel <= d[2:0];
        bit_val <= d[3];
        reg_rd <= (m == 0);
        reg_wr <= (m == 1);
        bit_wr <= (m == 2);
        @(posedge mclk);
        reg_rd <= 1'b0;
        reg_wr <= 1'b0;
        bit_wr <= 1'b0;
        @(posedge mclk);
        q = reg_rdata;
    endtask
    task automatic wr(input logic [7:0] a, d, input int m = 1);
        logic [7:0] q;
        bus(a, d, m, q);
    endtask
    task automatic rd_chk(input logic [7:0] a, exp);
        logic [7:0] q;
        bus(a, 8'h00, 0, q);
        check(q, exp);
    endtask
    task automatic ret();
        int_return <= 1'b1;
        @(posedge mclk);
        int_return <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic set_levels(input logic [17:0] lv);
        logic [15:0] h, l;
        h = 16'h0000;
        l = 16'h0000;
        lv_now = lv;
        for (int i = 0; i < 9; i++) begin
            h[BPOS[i] + (i > 6 ? 8 : 0)] = lv[2*i+1];
            l[BPOS[i] + (i > 6 ? 8 : 0)] = lv[2*i];
        end
        wr(8'hB7, h[7:0]);
        wr(8'hB8, l[7:0]);
        wr(8'hB3, h[15:8]);
        wr(8'hB2, l[15:8]);
    endtask
    // Raise flags, expect winner w (or none), let the core take it, then drop the flags
    task automatic expect_pick(input logic [8:0] s, input int w);
        logic [7:0] n0;
        n0 = taken_count;
        alt <= 8'(rnd()) | 8'h02;
        src <= s;
        repeat (2) @(posedge mclk);
        check(int_req, w >= 0);
        if (w >= 0) begin
            check(int_source, w[3:0]);
            check(int_vector, VEC[w]);
            check(int_level, lv_now[2*w+:2]);
            for (int k = 0; k < 8 && taken_count == n0; k++)
                @(posedge mclk);
            check(taken_vector, VEC[w]);
        end
        src <= 9'h000;
        @(posedge mclk);
    endtask
    task automatic give_verdict();
        $display("checks %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial begin
        logic [17:0] lv;
        logic [8:0]  s;
        logic [7:0]  em, ea, d;
        repeat (4) @(posedge mclk);
        nrst <= 1'b1;
        @(posedge mclk);
        // Reset values, then random data through the writable masks
        foreach (ADR[i]) rd_chk(ADR[i], 8'h00);
        foreach (ADR[i]) begin
            d = 8'(rnd()) & MSK[i];
            wr(ADR[i], d);
            rd_chk(ADR[i], d & MSK[i]);
        end
        wr(8'h10, 8'hFF);
        rd_chk(8'h10, 8'h00);
        wr(8'hA8, 8'h00);
        wr(8'hA8, 8'h0F, 2);
        rd_chk(8'hA8, 8'h80);
        wr(8'hB7, 8'h55);
        wr(8'hB7, 8'h09, 2);
        rd_chk(8'hB7, 8'h55);
        wr(8'hB8, 8'h00);
        wr(8'hB8, 8'h0E, 2);
        rd_chk(8'hB8, 8'h40);
        set_levels(18'h0);
        // Each source alone: blocked by its own enable, taken when enabled
        for (int i = 0; i < 9; i++) begin
            em = (i < 7) ? 8'h01 << BPOS[i] : 8'h00;
            ea = (i < 7) ? 8'h00 : 8'h01 << BPOS[i];
            ack_delay <= 2'(rnd());
            wr(8'hA8, 8'hFF ^ em);
            wr(8'hB1, 8'h05 ^ ea);
            expect_pick(9'h001 << i, -1);
            wr(8'hA8, 8'h80 | em);
            wr(8'hB1, ea);
            expect_pick(9'h001 << i, i);
            ret();
        end
        wr(8'hA8, 8'h7F);
        wr(8'hB1, 8'h05);
        expect_pick(9'h1FF, -1);
        wr(8'hA8, 8'hFF);
        // Random levels and flag sets
        for (int n = 0; n < 40; n++) begin
            lv = 18'(rnd());
            s = 9'(rnd());
            set_levels(lv);
            expect_pick(s, pick(s, lv, -1));
            if (s != 9'h000)
                ret();
        end
        // Nesting: equal level waits, higher preempts, top level is never preempted
        set_levels(18'h0C0E5);
        wr(8'hD9, 8'h0F);
        wr(8'hDA, 8'h02);
        expect_pick(9'h001, 0);
        expect_pick(9'h002, -1);
        expect_pick(9'h004, 2);
        expect_pick(9'h008, 3);
        expect_pick(9'h080, -1);
        rd_chk(8'hDB, 8'h0E);
        check(irq, 1'b1);
        rd_chk(8'hD9, 8'h03);
        wr(8'hD9, 8'h02);
        // Interrupt line is registered, so it falls one cycle after the clear
        @(posedge mclk);
        check(irq, 1'b0);
        repeat (4) ret();
        rd_chk(8'hD9, 8'h0D);
        give_verdict();
    end
endmodule
